//--- verilog/gost_defs.vh
`ifndef GOST_DEFS_VH
`define GOST_DEFS_VH

// register addresses on the host register port
`define GOST_ADDR_W          7
`define GOST_A_GYRO_X_TRIM   7'h00
`define GOST_A_GYRO_Y_TRIM   7'h01
`define GOST_A_GYRO_Z_TRIM   7'h02
`define GOST_A_ACCEL_X_TRIM  7'h0d
`define GOST_A_ACCEL_Y_TRIM  7'h0e
`define GOST_A_ACCEL_Z_TRIM  7'h0f
`define GOST_A_GYRO_X_BIAS_H 7'h13
`define GOST_A_GYRO_X_BIAS_L 7'h14
`define GOST_A_GYRO_Y_BIAS_H 7'h15
`define GOST_A_GYRO_Y_BIAS_L 7'h16
`define GOST_A_GYRO_Z_BIAS_H 7'h17
`define GOST_A_GYRO_Z_BIAS_L 7'h18

// trim code storage
`define GOST_TRIM_CNT        6
`define GOST_TRIM_IDX_W      3
`define GOST_TRIM_LAST       3'h5

// reset values
`define GOST_BIAS_RST        16'h0000
`define GOST_BYTE_RST        8'h00
`define GOST_SLEEP_RST       1'b1

// saturation limits of the signed output word
`define GOST_SAT_MAX         16'h7fff
`define GOST_SAT_MIN         16'h8000

// bias step in micro-dps per LSB; same for every axis
`define GOST_BIAS_STEP_UDPS  30500

`endif

//--- verilog/gost_trim_mem.v
`timescale 1ns/10ps
module gost_trim_mem #(
  parameter DEPTH = 6,
  parameter AW    = 3,
  parameter DW    = 8
) (
  // clock and reset
  input  wire          mclk,
  input  wire          rst_b,
  // write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  // read port, data one cycle after address
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data_r
);

  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge mclk) begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  always @(posedge mclk) begin
    if (!rst_b)
      rd_data_r <= {DW{1'b0}};
    else
      rd_data_r <= mem[rd_addr];
  end

endmodule // gost_trim_mem

//--- verilog/gost_regs.v
`timescale 1ns/10ps
`include "gost_defs.vh"
module gost_regs #(
  parameter AW = 7
) (
  // clock and reset
  input  wire         mclk,
  input  wire         rst_b,
  // host register port
  input  wire [AW-1:0] reg_addr,
  input  wire         reg_wr,
  input  wire [7:0]   reg_wdata,
  input  wire         reg_rd,
  output reg  [7:0]   reg_rdata_r,
  output reg          reg_rvalid_r,
  output reg          busy_r,
  // power configuration from the power block
  input  wire         pwr_cfg_wr,
  input  wire         pwr_cfg_sleep,
  output reg          sleep_r,
  // factory fuse codes, byte 0 = gyro x ... byte 5 = accel z
  input  wire [47:0]  otp_trim,
  // raw gyro samples
  input  wire         raw_valid,
  input  wire [15:0]  raw_x,
  input  wire [15:0]  raw_y,
  input  wire [15:0]  raw_z,
  // corrected output words
  output reg          out_valid_r,
  output reg  [15:0]  gyro_x_out_r,
  output reg  [15:0]  gyro_y_out_r,
  output reg  [15:0]  gyro_z_out_r
);

  localparam ST_LOAD = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [2:0]  load_idx_r;
  reg  [7:0]  bias_h_r [0:2];
  reg  [7:0]  bias_l_r [0:2];
  reg  [15:0] bias_r   [0:2];
  reg  [2:0]  seen_h_r;
  reg  [2:0]  seen_l_r;
  reg         rd_p1_r;
  reg         trim_p1_r;
  reg  [7:0]  loc_p1_r;
  reg  [7:0]  loc_val;
  wire [7:0]  mem_rdata;
  wire        run;
  wire        host_trim_wr;
  wire        mem_we;
  wire [2:0]  mem_waddr;
  wire [7:0]  mem_wdata;
  integer     i;

  // maps a trim address to its storage slot; 3'h7 when not a trim address
  function [2:0] trim_idx;
    input [AW-1:0] a;
    begin
      case (a)
        `GOST_A_GYRO_X_TRIM:  trim_idx = 3'h0;
        `GOST_A_GYRO_Y_TRIM:  trim_idx = 3'h1;
        `GOST_A_GYRO_Z_TRIM:  trim_idx = 3'h2;
        `GOST_A_ACCEL_X_TRIM: trim_idx = 3'h3;
        `GOST_A_ACCEL_Y_TRIM: trim_idx = 3'h4;
        `GOST_A_ACCEL_Z_TRIM: trim_idx = 3'h5;
        default:              trim_idx = 3'h7;
      endcase
    end
  endfunction

  // signed add with clamping instead of wrap
  function [15:0] sat_add;
    input [15:0] s;
    input [15:0] b;
    reg   [16:0] sum;
    begin
      sum = {s[15], s} + {b[15], b};
      if (sum[16] != sum[15])
        sat_add = sum[16] ? `GOST_SAT_MIN : `GOST_SAT_MAX;
      else
        sat_add = sum[15:0];
    end
  endfunction

  assign run          = state_r[1];
  assign host_trim_wr = run & reg_wr & (trim_idx(reg_addr) != 3'h7);
  // fuse copy first, then host writes; codes survive until overwritten
  assign mem_we    = state_r[0] | host_trim_wr;
  assign mem_waddr = state_r[0] ? load_idx_r : trim_idx(reg_addr);
  assign mem_wdata = state_r[0] ? otp_trim[load_idx_r*8 +: 8] : reg_wdata;

  gost_trim_mem #(
    .DEPTH (`GOST_TRIM_CNT),
    .AW    (`GOST_TRIM_IDX_W),
    .DW    (8)
  ) u_trim (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .wr_en     (mem_we),
    .wr_addr   (mem_waddr),
    .wr_data   (mem_wdata),
    .rd_addr   (trim_idx(reg_addr)),
    .rd_data_r (mem_rdata)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_LOAD: if (load_idx_r == `GOST_TRIM_LAST) state_nxt = ST_RUN;
      ST_RUN:  state_nxt = ST_RUN;
      default: state_nxt = ST_LOAD;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_b) begin
      state_r    <= ST_LOAD;
      load_idx_r <= 3'h0;
      busy_r     <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      busy_r     <= (state_nxt != ST_RUN);
      if (state_r[0])
        load_idx_r <= load_idx_r + 3'h1;
    end
  end

  // power-up lands in sleep; only a power configuration write leaves it
  always @(posedge mclk) begin
    if (!rst_b)
      sleep_r <= `GOST_SLEEP_RST;
    else if (pwr_cfg_wr)
      sleep_r <= pwr_cfg_sleep;
  end

  // bias bytes; the working word updates once both halves have arrived
  always @(posedge mclk) begin
    if (!rst_b) begin
      seen_h_r <= 3'h0;
      seen_l_r <= 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
        bias_h_r[i] <= `GOST_BYTE_RST;
        bias_l_r[i] <= `GOST_BYTE_RST;
        bias_r[i]   <= `GOST_BIAS_RST;
      end
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        if (seen_h_r[i] && seen_l_r[i]) begin
          bias_r[i]   <= {bias_h_r[i], bias_l_r[i]};
          seen_h_r[i] <= 1'b0;
          seen_l_r[i] <= 1'b0;
        end
        // a byte written in the commit cycle starts the next pair
        if (run && reg_wr && reg_addr == `GOST_A_GYRO_X_BIAS_H + 2*i) begin
          bias_h_r[i] <= reg_wdata;
          seen_h_r[i] <= 1'b1;
        end
        if (run && reg_wr && reg_addr == `GOST_A_GYRO_X_BIAS_L + 2*i) begin
          bias_l_r[i] <= reg_wdata;
          seen_l_r[i] <= 1'b1;
        end
      end
    end
  end

  always @* begin
    loc_val = 8'h00;
    case (reg_addr)
      `GOST_A_GYRO_X_BIAS_H: loc_val = bias_h_r[0];
      `GOST_A_GYRO_X_BIAS_L: loc_val = bias_l_r[0];
      `GOST_A_GYRO_Y_BIAS_H: loc_val = bias_h_r[1];
      `GOST_A_GYRO_Y_BIAS_L: loc_val = bias_l_r[1];
      `GOST_A_GYRO_Z_BIAS_H: loc_val = bias_h_r[2];
      `GOST_A_GYRO_Z_BIAS_L: loc_val = bias_l_r[2];
      default:               loc_val = 8'h00;
    endcase
  end

  // two-stage read so trim and bias answers share one latency
  always @(posedge mclk) begin
    if (!rst_b) begin
      rd_p1_r      <= 1'b0;
      trim_p1_r    <= 1'b0;
      loc_p1_r     <= 8'h00;
      reg_rvalid_r <= 1'b0;
      reg_rdata_r  <= 8'h00;
    end else begin
      rd_p1_r      <= reg_rd;
      trim_p1_r    <= run & (trim_idx(reg_addr) != 3'h7);
      loc_p1_r     <= loc_val;
      reg_rvalid_r <= rd_p1_r;
      if (rd_p1_r)
        reg_rdata_r <= trim_p1_r ? mem_rdata : loc_p1_r;
    end
  end

  // bias LSB and sample LSB are the same step, so no scaling here
  always @(posedge mclk) begin
    if (!rst_b) begin
      out_valid_r  <= 1'b0;
      gyro_x_out_r <= 16'h0000;
      gyro_y_out_r <= 16'h0000;
      gyro_z_out_r <= 16'h0000;
    end else begin
      out_valid_r <= raw_valid & ~sleep_r;
      if (raw_valid && !sleep_r) begin
        gyro_x_out_r <= sat_add(raw_x, bias_r[0]);
        gyro_y_out_r <= sat_add(raw_y, bias_r[1]);
        gyro_z_out_r <= sat_add(raw_z, bias_r[2]);
      end
    end
  end

endmodule // gost_regs

//--- tb/gost_regs_sva.sv
`timescale 1ns/10ps
module gost_regs_sva (
  // clock and reset
  input logic        mclk,
  input logic        rst_b,
  // watched ports
  input logic        reg_rd,
  input logic        reg_rvalid_r,
  input logic        busy_r,
  input logic        pwr_cfg_wr,
  input logic        pwr_cfg_sleep,
  input logic        sleep_r,
  input logic        raw_valid,
  input logic        out_valid_r,
  input logic [15:0] gyro_x_out_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_rd; reg_rd; endsequence
  sequence s_ans; ##2 reg_rvalid_r; endsequence
  a_read_answer: assert property (s_rd |-> s_ans)
    else $error("read not answered");
  a_no_stray: assert property (reg_rvalid_r |-> $past(reg_rd, 2))
    else $error("answer without read");
  a_sleep_set: assert property (
    pwr_cfg_wr |=> sleep_r == $past(pwr_cfg_sleep))
    else $error("sleep not loaded");
  a_sleep_keep: assert property (!pwr_cfg_wr |=> $stable(sleep_r))
    else $error("sleep changed alone");
  a_out_answer: assert property (
    raw_valid && !sleep_r |=> out_valid_r)
    else $error("sample lost");
  a_out_cause: assert property (
    out_valid_r |-> $past(raw_valid) && !$past(sleep_r))
    else $error("sample without cause");
  a_out_hold: assert property (
    !out_valid_r |-> $stable(gyro_x_out_r))
    else $error("output moved");
  a_boot_copy: assert property ($rose(rst_b) |-> ##[1:7] !busy_r)
    else $error("copy too long");
  a_busy_once: assert property (!busy_r |=> !busy_r)
    else $error("busy again");
endmodule // gost_regs_sva

bind gost_regs gost_regs_sva chk_u (.mclk(mclk), .rst_b(rst_b),
  .reg_rd(reg_rd), .reg_rvalid_r(reg_rvalid_r), .busy_r(busy_r),
  .pwr_cfg_wr(pwr_cfg_wr), .pwr_cfg_sleep(pwr_cfg_sleep), .sleep_r(sleep_r),
  .raw_valid(raw_valid), .out_valid_r(out_valid_r),
  .gyro_x_out_r(gyro_x_out_r));

//--- tb/gost_host.sv
`timescale 1ns/10ps
module gost_host (
  // clock
  input  logic       mclk,
  // register port
  output logic [6:0] reg_addr,
  output logic       reg_wr,
  output logic [7:0] reg_wdata,
  output logic       reg_rd,
  input  logic [7:0] reg_rdata_r,
  input  logic       reg_rvalid_r
);
  initial begin
    reg_addr = 7'h7f;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // data inverted after the strobe so a stale byte never looks valid
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // host-side reference: rebuild the factory response from a code
  function automatic real st_resp(input logic [7:0] c,
                                  input int full_scale_setting);
    real base;
    base = 1310.0 / (2.0 ** full_scale_setting);
    return base * (1.01 ** (c - 1.0));
  endfunction
  // inverse: rounded base-1.01 log of the scaled response, plus one
  function automatic logic [7:0] trim_code_value(input real r,
                                         input int full_scale_setting);
    real base;
    base = 1310.0 / (2.0 ** full_scale_setting);
    return 8'($rtoi($floor($ln(r / base) / $ln(1.01) + 0.5)) + 1);
  endfunction
  task automatic rd(input logic [6:0] a, output logic [7:0] d,
                    output logic ok);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    repeat (4) begin
      @(posedge mclk);
      #1;
      if (reg_rvalid_r && !ok) begin
        ok = 1'b1;
        d = reg_rdata_r;
      end
    end
  endtask
endmodule // gost_host

//--- tb/gost_regs_test.sv
`timescale 1ns/10ps
module gost_regs_test;
  logic        mclk, rst_b, pwr_cfg_wr, pwr_cfg_sleep, raw_valid, ok;
  logic        reg_wr, reg_rd, reg_rvalid_r, busy_r, sleep_r, out_valid_r;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata_r, rd_v, a, code_v;
  logic [15:0] raw_x, raw_y, raw_z, gyro_x_out_r, gyro_y_out_r, gyro_z_out_r;
  logic [47:0] otp_trim;
  logic [15:0] rows [13];
  integer      n_mismatch, compares, i;
  gost_regs dut_u (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .busy_r(busy_r),
    .pwr_cfg_wr(pwr_cfg_wr), .pwr_cfg_sleep(pwr_cfg_sleep), .sleep_r(sleep_r),
    .otp_trim(otp_trim), .raw_valid(raw_valid), .raw_x(raw_x), .raw_y(raw_y),
    .raw_z(raw_z), .out_valid_r(out_valid_r), .gyro_x_out_r(gyro_x_out_r),
    .gyro_y_out_r(gyro_y_out_r), .gyro_z_out_r(gyro_z_out_r));
  gost_host host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    compares = compares + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic rdc(input logic [6:0] ad, input logic [7:0] e);
    host_u.rd(ad, rd_v, ok);
    chk("rvalid", 16'h1, {15'h0, ok});
    if (ok !== 1'b1)
      finish_test;
    chk("rdata", {8'h0, e}, {8'h0, rd_v});
  endtask
  // reset and the values it must leave, then wait out the fuse copy until busy drops
  task automatic boot;
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    chk("rst sleep", 16'h1, {15'h0, sleep_r});
    chk("rst busy", 16'h1, {15'h0, busy_r});
    chk("rst out", 16'h0, gyro_x_out_r);
    chk("rst rdata", 16'h0, {8'h0, reg_rdata_r});
    rst_b = 1'b1;
    for (i = 0; i < 10 && busy_r !== 1'b0; i++) @(negedge mclk);
    chk("busy", 16'h0, {15'h0, busy_r});
    if (busy_r !== 1'b0)
      finish_test;
  endtask
  task automatic smp(input logic [15:0] x, y, z);
    @(negedge mclk);
    {raw_x, raw_y, raw_z} = {x, y, z};
    raw_valid = 1'b1;
    @(negedge mclk);
    raw_valid = 1'b0;
    {raw_x, raw_y, raw_z} = ~{x, y, z};
  endtask
  initial begin
    n_mismatch = 0;
    compares = 0;
    {pwr_cfg_wr, pwr_cfg_sleep, raw_valid} = 3'h2;
    {raw_x, raw_y, raw_z} = 48'h0;
    otp_trim = 48'h665544332211;
    rows = '{16'h0011, 16'h0122, 16'h0233, 16'h0d44, 16'h0e55, 16'h0f66,
      16'h1000, 16'h1300, 16'h1400, 16'h1500, 16'h1600, 16'h1700, 16'h1800};
    boot;
    chk("sleep", 16'h1, {15'h0, sleep_r});
    smp(16'h0100, 16'h0100, 16'h0100);
    chk("asleep", 16'h0, {15'h0, out_valid_r});
    for (i = 0; i < 13; i++) begin
      rdc(rows[i][14:8], rows[i][7:0]);
      code_v = host_u.trim_code_value(host_u.st_resp(rd_v, i % 4), i % 4);
      chk("code", {8'h0, rows[i][7:0]}, {8'h0, code_v});
    end
    for (i = 0; i < 13; i++) begin
      a = rows[i][15:8];
      host_u.wr(a[6:0], a ^ 8'ha5);
      rdc(a[6:0], a == 8'h10 ? 8'h00 : a ^ 8'ha5);
    end
    @(negedge mclk);
    {pwr_cfg_wr, pwr_cfg_sleep} = 2'h2;
    @(negedge mclk);
    {pwr_cfg_wr, pwr_cfg_sleep} = 2'h1;
    chk("awake", 16'h0, {15'h0, sleep_r});
    smp(16'h8000, 16'h1234, 16'h7fff);
    chk("valid", 16'h1, {15'h0, out_valid_r});
    chk("x", 16'h8000, gyro_x_out_r);
    chk("y", 16'h1234 + 16'hb0b3, gyro_y_out_r);
    chk("z", 16'h7fff + 16'hb2bd, gyro_z_out_r);
    host_u.wr(7'h13, 8'h7f);
    smp(16'h0000, 16'h0000, 16'h0000);
    chk("x torn", 16'hb6b1, gyro_x_out_r);
    host_u.wr(7'h14, 8'hff);
    smp(16'h7fff, 16'h0000, 16'h0000);
    chk("x max", 16'h7fff, gyro_x_out_r);
    smp(16'h8001, 16'h0000, 16'h0000);
    chk("x word", 16'h0000, gyro_x_out_r);
    boot;
    rdc(7'h00, 8'h11);
    rdc(7'h13, 8'h00);
    finish_test;
  end
endmodule // gost_regs_test
